//--- hdl/rsps_top.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
// ********************
// start-up switch decode, protocol latch and factory reset
// ********************
module rsps_top #(
   parameter int unsigned INIT_CYCLES = rsps_pkg::INIT_CYC,
   parameter int unsigned BLINK_HALF  = rsps_pkg::BLINK_CYC
) (
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic                    irq,
   // rotary switches
   input  wire rsps_pkg::rsps_sw_t switches,
   // non-volatile parameter store
   input  wire logic               nv_saved,
   input  wire rsps_pkg::rsps_net_t nv_net,
   input  wire logic               nv_proto_valid,
   input  wire logic [3:0]         nv_proto,
   input  wire logic               nv_done,
   output logic                    nv_wr_proto,
   output logic [3:0]              nv_wr_proto_val,
   output logic                    nv_factory,
   // protocol stack
   input  wire logic               cyclic_start,
   input  wire logic               proto_init_done,
   output logic                    proto_init,
   output logic [3:0]              proto_sel,
   output rsps_pkg::rsps_net_t     net_cfg,
   output logic                    net_en,
   // indicators
   input  wire logic               supply_ok,
   output logic                    run_indicator,
   output logic                    system_supply_indicator_red,
   output logic                    system_supply_indicator_green
);
   if (INIT_CYCLES < 1) $error("rsps_top: INIT_CYCLES must be >= 1");

   // ********************
   // state
   // ********************
   rsps_pkg::rsps_state_t st_q, st_d;
   rsps_pkg::rsps_sw_t    sw_q, sw_d;
   rsps_pkg::rsps_net_t   nvn_q, nvn_d, net_q, net_d;
   logic       nvs_q, nvs_d, pv_q, pv_d;
   logic [3:0] nvp_q, nvp_d, proto_q, proto_d;
   logic       bad_q, bad_d, stored_q, stored_d, busy_q, busy_d;
   logic       wrp_q, wrp_d, fac_q, fac_d, pin_q, pin_d;
   logic [31:0] cnt_q, cnt_d;
   logic       runl_q, runl_d, red_q, red_d, grn_q, grn_d;
   logic       blink, blink_run;
   logic [rsps_pkg::IRQ_W-1:0] ev, ist_q, ist_d, imsk_q, imsk_d;
   logic       wr_acc, restart;
   logic [31:0] rd_d, prdata_q;
   logic       rdy_q, rdy_d, err_q, err_d, hit;

   // ********************
   // switch decode
   // ********************
   logic       digits_ok, is_fact, dec_ok;
   logic [7:0] octet;
   logic [3:0] dec_proto;
   rsps_pkg::rsps_net_t base, dec_net;

   // decode works only on the copies taken at start-up
   always_comb begin
      digits_ok = (sw_q.hundreds_switch <= rsps_pkg::DIGIT_MAX) &&
                  (sw_q.tens_switch <= rsps_pkg::DIGIT_MAX) &&
                  (sw_q.ones_switch <= rsps_pkg::DIGIT_MAX);
      is_fact   = (sw_q.hundreds_switch == rsps_pkg::FACT_H) &&
                  (sw_q.tens_switch == rsps_pkg::FACT_T) &&
                  (sw_q.ones_switch == rsps_pkg::FACT_O);
      // tens and ones form one decimal octet, above 99 only for digits that digits_ok rejects
      octet     = 8'({4'h0, sw_q.tens_switch} * rsps_pkg::DEC_BASE) +
                  {4'h0, sw_q.ones_switch};
      // a stored protocol overrides the switch
      dec_proto = pv_q ? nvp_q : sw_q.hundreds_switch;
      // saved parameters if present, otherwise the defaults
      if (nvs_q) begin
         base = nvn_q;
      end else begin
         base.mode = rsps_pkg::MODE_STAT;
         base.ip   = {rsps_pkg::DEF_PREFIX, 8'h00};
         base.mask = rsps_pkg::DEF_MASK;
         base.gw   = rsps_pkg::DEF_GW;
      end
      dec_net = base;
      dec_ok  = digits_ok && (dec_proto != rsps_pkg::PROTO_RSV);
      if (dec_proto == rsps_pkg::PROTO_OWN) begin
         if (octet >= rsps_pkg::OCT_MIN) begin
            dec_net.ip[7:0] = octet;
         end else if (!nvs_q) begin
            dec_ok = 1'b0;
         end
         // 600 with saved parameters keeps them whole
      end
   end

   // ********************
   // sequencer
   // ********************
   // one pass per start-up; only a restart goes back to sampling
   always_comb begin
      st_d     = st_q;
      sw_d     = sw_q;
      nvn_d    = nvn_q;
      nvs_d    = nvs_q;
      pv_d     = pv_q;
      nvp_d    = nvp_q;
      net_d    = net_q;
      proto_d  = proto_q;
      bad_d    = bad_q;
      stored_d = stored_q;
      busy_d   = busy_q;
      cnt_d    = cnt_q;
      wrp_d    = 1'b0;
      fac_d    = 1'b0;
      pin_d    = 1'b0;
      ev       = '0;
      case (st_q)
         rsps_pkg::ST_SAMPLE: begin
            // one-cycle capture of switches and store
            sw_d     = switches;
            nvn_d    = nv_net;
            nvs_d    = nv_saved;
            pv_d     = nv_proto_valid;
            nvp_d    = nv_proto;
            stored_d = nv_proto_valid;
            bad_d    = 1'b0;
            busy_d   = 1'b0;
            st_d     = rsps_pkg::ST_DECIDE;
         end
         rsps_pkg::ST_DECIDE: begin
            if (is_fact) begin
               fac_d = 1'b1;
               st_d  = rsps_pkg::ST_FACT;
            end else if (!dec_ok) begin
               bad_d = 1'b1;
               ev[rsps_pkg::IRQ_INVALID] = 1'b1;
               st_d  = rsps_pkg::ST_HALT;
            end else begin
               net_d   = dec_net;
               proto_d = dec_proto;
               pin_d   = 1'b1;
               cnt_d   = '0;
               st_d    = rsps_pkg::ST_INIT;
            end
         end
         rsps_pkg::ST_FACT: begin
            // network stays off here and in the halt that follows the store's confirm
            if (nv_done) begin
               stored_d = 1'b0;
               ev[rsps_pkg::IRQ_FACT] = 1'b1;
               st_d = rsps_pkg::ST_HALT;
            end
         end
         rsps_pkg::ST_INIT: begin
            // bounded wait for the stack to come up
            if (proto_init_done || cnt_q == 32'(INIT_CYCLES - 1)) begin
               ev[rsps_pkg::IRQ_READY] = 1'b1;
               st_d = rsps_pkg::ST_RUN;
            end else begin
               cnt_d = cnt_q + 32'h00000001;
            end
         end
         rsps_pkg::ST_RUN: begin
            // first cyclic exchange writes the protocol once
            if (cyclic_start && !stored_q && !busy_q) begin
               wrp_d  = 1'b1;
               busy_d = 1'b1;
            end
            if (busy_q && nv_done) begin
               busy_d   = 1'b0;
               stored_d = 1'b1;
               ev[rsps_pkg::IRQ_STORED] = 1'b1;
            end
         end
         rsps_pkg::ST_HALT: begin
            st_d = rsps_pkg::ST_HALT;
         end
         default: begin
            st_d = rsps_pkg::ST_SAMPLE;
         end
      endcase
      // switch changes matter only through this restart path
      if (restart) begin
         st_d = rsps_pkg::ST_SAMPLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q     <= rsps_pkg::ST_SAMPLE;
         sw_q     <= '0;
         nvn_q    <= '0;
         nvs_q    <= 1'b0;
         pv_q     <= 1'b0;
         nvp_q    <= '0;
         net_q    <= '0;
         proto_q  <= '0;
         bad_q    <= 1'b0;
         stored_q <= 1'b0;
         busy_q   <= 1'b0;
         cnt_q    <= '0;
         wrp_q    <= 1'b0;
         fac_q    <= 1'b0;
         pin_q    <= 1'b0;
      end else begin
         st_q     <= st_d;
         sw_q     <= sw_d;
         nvn_q    <= nvn_d;
         nvs_q    <= nvs_d;
         pv_q     <= pv_d;
         nvp_q    <= nvp_d;
         net_q    <= net_d;
         proto_q  <= proto_d;
         bad_q    <= bad_d;
         stored_q <= stored_d;
         busy_q   <= busy_d;
         cnt_q    <= cnt_d;
         wrp_q    <= wrp_d;
         fac_q    <= fac_d;
         pin_q    <= pin_d;
      end
   end

   // ********************
   // indicators
   // ********************
   // one blinker serves both lamps since their blink states never overlap
   assign blink_run = (st_q == rsps_pkg::ST_FACT) ||
                      (st_q == rsps_pkg::ST_HALT && bad_q);

   rsps_blink #(
      .HALF    (BLINK_HALF)
   ) u_blink (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (blink_run),
      .blink   (blink)
   );

   always_comb begin
      runl_d = 1'b0;
      red_d  = ~supply_ok;
      grn_d  = supply_ok;
      case (st_q)
         rsps_pkg::ST_FACT: begin
            red_d = blink;
            grn_d = 1'b0;
         end
         rsps_pkg::ST_INIT: begin
            red_d = 1'b0;
            grn_d = 1'b0;
         end
         rsps_pkg::ST_RUN: begin
            runl_d = 1'b1;
         end
         rsps_pkg::ST_HALT: begin
            runl_d = bad_q & blink;
         end
         default: begin
            runl_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         runl_q <= 1'b0;
         red_q  <= 1'b0;
         grn_q  <= 1'b0;
      end else begin
         runl_q <= runl_d;
         red_q  <= red_d;
         grn_q  <= grn_d;
      end
   end

   // ********************
   // apb slave and interrupts
   // ********************
   assign wr_acc  = psel & penable & pready & pwrite;
   assign restart = wr_acc && paddr == rsps_pkg::REG_CTRL &&
                    pwdata[rsps_pkg::CTRL_RESTART];

   // read data is staged in the setup cycle: zero-wait access phase
   always_comb begin
      hit  = 1'b1;
      rd_d = '0;
      case (paddr)
         rsps_pkg::REG_CTRL:    rd_d = '0;
         rsps_pkg::REG_STAT:    rd_d = {19'h0, fac_q, proto_q, 1'b0,
                                        net_q.mode, net_en, stored_q,
                                        bad_q, st_q};
         rsps_pkg::REG_IP:      rd_d = net_q.ip;
         rsps_pkg::REG_MASK:    rd_d = net_q.mask;
         rsps_pkg::REG_GW:      rd_d = net_q.gw;
         rsps_pkg::REG_IRQ_ST:  rd_d = {28'h0, ist_q};
         rsps_pkg::REG_IRQ_MSK: rd_d = {28'h0, imsk_q};
         default:               hit  = 1'b0;
      endcase
      rdy_d  = psel & ~penable;
      err_d  = psel & ~penable & ~hit;
      imsk_d = imsk_q;
      if (wr_acc && paddr == rsps_pkg::REG_IRQ_MSK) begin
         imsk_d = pwdata[rsps_pkg::IRQ_W-1:0];
      end
      // a new event wins over a same-cycle write-one clear
      ist_d = ist_q | ev;
      if (wr_acc && paddr == rsps_pkg::REG_IRQ_ST) begin
         ist_d = (ist_q & ~pwdata[rsps_pkg::IRQ_W-1:0]) | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
         rdy_q    <= 1'b0;
         err_q    <= 1'b0;
         ist_q    <= '0;
         imsk_q   <= '0;
      end else begin
         prdata_q <= (psel & ~penable) ? rd_d : prdata_q;
         rdy_q    <= rdy_d;
         err_q    <= err_d;
         ist_q    <= ist_d;
         imsk_q   <= imsk_d;
      end
   end

   // ********************
   // outputs
   // ********************
   assign prdata          = prdata_q;
   assign pready          = rdy_q;
   assign pslverr         = err_q;
   assign irq             = |(ist_q & imsk_q);
   assign nv_wr_proto     = wrp_q;
   assign nv_wr_proto_val = proto_q;
   assign nv_factory      = fac_q;
   assign proto_init      = pin_q;
   assign proto_sel       = proto_q;
   assign net_cfg         = net_q;
   // network off outside run, so also during factory reset
   assign net_en          = (st_q == rsps_pkg::ST_RUN);
   assign run_indicator   = runl_q;
   assign system_supply_indicator_red   = red_q;
   assign system_supply_indicator_green = grn_q;
endmodule

//--- hdl/rsps_pkg.sv
package rsps_pkg;
   // ********************
   // timing
   // ********************
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned INIT_MAX_S    = 15;
   localparam int unsigned INIT_CYC      = INIT_MAX_S * CLK_HZ;
   localparam int unsigned BLINK_HALF_MS = 250;
   localparam int unsigned BLINK_CYC     = BLINK_HALF_MS * (CLK_HZ / 1000);

   // ********************
   // switch codes and network defaults
   // ********************
   localparam logic [3:0]  DIGIT_MAX  = 4'h9;
   localparam logic [3:0]  FACT_H     = 4'h9;
   localparam logic [3:0]  FACT_T     = 4'h7;
   localparam logic [3:0]  FACT_O     = 4'h9;
   localparam logic [3:0]  PROTO_OWN  = 4'h6;
   localparam logic [3:0]  PROTO_RSV  = 4'h9;
   localparam logic [7:0]  DEC_BASE   = 8'h0A;
   localparam logic [7:0]  OCT_MIN    = 8'h01;
   localparam logic [23:0] DEF_PREFIX = 24'hC0A803;
   localparam logic [31:0] DEF_MASK   = 32'hFFFFFF00;
   localparam logic [31:0] DEF_GW     = 32'hC0A80364;
   localparam logic        MODE_STAT  = 1'b0;

   // ********************
   // register map (byte addresses)
   // ********************
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_STAT    = 8'h04;
   localparam logic [7:0] REG_IP      = 8'h08;
   localparam logic [7:0] REG_MASK    = 8'h0C;
   localparam logic [7:0] REG_GW      = 8'h10;
   localparam logic [7:0] REG_IRQ_ST  = 8'h14;
   localparam logic [7:0] REG_IRQ_MSK = 8'h18;
   localparam int CTRL_RESTART = 0;
   localparam int IRQ_READY    = 0;
   localparam int IRQ_INVALID  = 1;
   localparam int IRQ_FACT     = 2;
   localparam int IRQ_STORED   = 3;
   localparam int IRQ_W        = 4;

   // ********************
   // types
   // ********************
   typedef struct packed {
      logic [3:0] hundreds_switch;
      logic [3:0] tens_switch;
      logic [3:0] ones_switch;
   } rsps_sw_t;

   typedef struct packed {
      logic        mode;
      logic [31:0] ip;
      logic [31:0] mask;
      logic [31:0] gw;
   } rsps_net_t;

   typedef enum logic [2:0] {
      ST_SAMPLE = 3'b000,
      ST_DECIDE = 3'b001,
      ST_INIT   = 3'b011,
      ST_RUN    = 3'b010,
      ST_FACT   = 3'b110,
      ST_HALT   = 3'b111
   } rsps_state_t;
endpackage

//--- hdl/rsps_blink.sv
`timescale 1ns/10ps
// ********************
// blink generator: square wave while run is high
// ********************
module rsps_blink #(
   parameter int unsigned HALF = rsps_pkg::BLINK_CYC
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control and wave
   input  wire logic run,
   output logic      blink
);
   if (HALF < 1) $error("rsps_blink: HALF must be at least one");

   logic [31:0] cnt_q, cnt_d;
   logic        lvl_q, lvl_d;

   // restart from dark each time run rises, so every blink looks alike
   always_comb begin
      cnt_d = cnt_q;
      lvl_d = lvl_q;
      if (!run) begin
         cnt_d = '0;
         lvl_d = 1'b0;
      end else if (cnt_q == 32'(HALF - 1)) begin
         cnt_d = '0;
         lvl_d = ~lvl_q;
      end else begin
         cnt_d = cnt_q + 32'h00000001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         lvl_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
      end
   end

   assign blink = lvl_q;
endmodule

//--- verification/rsps_nv_model.sv
`timescale 1ns/10ps
// ********************
// parameter store model
// ********************
module rsps_nv_model #(
   parameter int WDLY = 4,
   parameter int FDLY = 30
) (
   // clock
   input  wire logic           pclk,
   // requests from the loader
   input  wire logic           nv_wr_proto,
   input  wire logic [3:0]     nv_wr_proto_val,
   input  wire logic           nv_factory,
   // stored contents
   output logic                nv_saved,
   output rsps_pkg::rsps_net_t nv_net,
   output logic                nv_proto_valid,
   output logic [3:0]          nv_proto,
   output logic                nv_done
);
   logic                saved_q, pv_q, fact_q;
   logic [3:0]          proto_q, wval_q;
   rsps_pkg::rsps_net_t net_q;
   int                  cnt_q;

   // empty store at power-up; no reset pin, the memory outlives resets
   initial begin
      saved_q = 1'b0;
      pv_q    = 1'b0;
      proto_q = 4'h0;
      fact_q  = 1'b0;
      cnt_q   = 0;
      nv_done = 1'b0;
   end

   // empty slots show inverted garbage so a stale value never looks valid
   assign nv_saved       = saved_q;
   assign nv_proto_valid = pv_q;
   assign nv_net         = saved_q ? net_q : ~net_q;
   assign nv_proto       = pv_q ? proto_q : ~proto_q;

   // one write at a time; requests during a busy write are not queued
   always @(posedge pclk) begin
      nv_done <= 1'b0;
      if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
         if (cnt_q == 1) begin
            nv_done <= 1'b1;
            if (fact_q) begin
               saved_q <= 1'b0;
               pv_q    <= 1'b0;
            end else begin
               pv_q    <= 1'b1;
               proto_q <= wval_q;
            end
         end
      end else if (nv_factory) begin
         cnt_q  <= FDLY;
         fact_q <= 1'b1;
      end else if (nv_wr_proto) begin
         cnt_q  <= WDLY;
         fact_q <= 1'b0;
         wval_q <= nv_wr_proto_val;
      end
   end
endmodule

//--- verification/rsps_top_sva.sv
`timescale 1ns/10ps
// ********************
// port checks of the start-up loader
// ********************
module rsps_top_sva #(
   parameter int unsigned INIT_CYCLES = 20,
   parameter int unsigned BLINK_HALF  = 3
) (
   // clock and reset
   input logic                pclk,
   input logic                presetn,
   // apb
   input logic                psel,
   input logic                penable,
   input logic                pready,
   input logic                pslverr,
   // store and stack
   input logic                nv_saved,
   input logic                nv_wr_proto,
   input logic [3:0]          nv_wr_proto_val,
   input logic                nv_factory,
   input logic                cyclic_start,
   input logic                proto_init,
   input logic [3:0]          proto_sel,
   input rsps_pkg::rsps_net_t net_cfg,
   input logic                net_en,
   // indicators
   input logic                supply_ok,
   input logic                run_indicator,
   input logic                system_supply_indicator_red,
   input logic                system_supply_indicator_green
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_pready_setup: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_err_access: assert property (pslverr |-> pready && psel && penable)
      else $error("error flag outside access");
   a_cfg_hold: assert property (
      net_en && $past(net_en) |-> $stable(net_cfg) && $stable(proto_sel))
      else $error("config moved while running");
   a_fact_quiet: assert property (
      nv_factory |=> (!net_en && !proto_init) [*8])
      else $error("network active in factory reset");
   a_fact_dark: assert property (
      nv_factory |=> !system_supply_indicator_green [*8])
      else $error("green lamp in factory reset");
   a_fact_blink: assert property (
      (BLINK_HALF < 6) && nv_factory |-> ##[1:12] system_supply_indicator_red)
      else $error("red lamp not blinking");
   a_ip_prefix: assert property (
      net_en && !nv_saved && proto_sel == rsps_pkg::PROTO_OWN |->
         net_cfg.ip[31:8] == rsps_pkg::DEF_PREFIX
         && net_cfg.ip[7:0] inside {[8'h01:8'h63]})
      else $error("switch address out of range");
   a_net_default: assert property (
      net_en && !nv_saved |-> net_cfg.mask == rsps_pkg::DEF_MASK
         && net_cfg.gw == rsps_pkg::DEF_GW
         && net_cfg.mode == rsps_pkg::MODE_STAT)
      else $error("default parameters wrong");
   a_store_value: assert property (
      nv_wr_proto |-> net_en && nv_wr_proto_val == proto_sel)
      else $error("stored protocol differs");
   a_store_cause: assert property (
      nv_wr_proto |-> $past(cyclic_start) ##1 !nv_wr_proto)
      else $error("store without cyclic start");
   a_supply_lamp: assert property (
      net_en && $past(net_en) && $stable(supply_ok) |->
         system_supply_indicator_green == supply_ok
         && system_supply_indicator_red == !supply_ok)
      else $error("supply lamp wrong");
   a_run_lamp: assert property (net_en && $past(net_en) |-> run_indicator)
      else $error("run lamp dark while running");
   a_init_pulse: assert property (
      proto_init |-> !net_en ##1 !proto_init)
      else $error("init pulse malformed");
endmodule

//--- verification/rsps_top_tb.sv
`timescale 1ns/10ps
module rsps_top_tb;
   // ********************
   // bench signals
   // ********************
   localparam int unsigned INIT_C  = 20;
   localparam int unsigned BLINK_C = 3;
   logic                pclk, presetn, psel, penable, pwrite, pready;
   logic                pslverr, irq, err, red, green, auto_done;
   logic                nv_saved, nv_proto_valid, nv_done, nv_factory;
   logic                nv_wr_proto, cyclic_start, proto_init_done;
   logic                proto_init, net_en, supply_ok, run_indicator;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic [3:0]          nv_proto, nv_wr_proto_val, proto_sel;
   logic [11:0]         bad [3] = '{12'h600, 12'hA10, 12'h910};
   rsps_pkg::rsps_sw_t  switches;
   rsps_pkg::rsps_net_t nv_net, net_cfg;
   int                  failures, n_checks, cyc, hi;

   rsps_top #(.INIT_CYCLES(INIT_C), .BLINK_HALF(BLINK_C)) dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq, .switches, .nv_saved, .nv_net,
      .nv_proto_valid, .nv_proto, .nv_done, .nv_wr_proto, .nv_wr_proto_val,
      .nv_factory, .cyclic_start, .proto_init_done, .proto_init,
      .proto_sel, .net_cfg, .net_en, .supply_ok, .run_indicator,
      .system_supply_indicator_red(red),
      .system_supply_indicator_green(green));
   rsps_nv_model nv_u (
      .pclk, .nv_wr_proto, .nv_wr_proto_val, .nv_factory, .nv_saved,
      .nv_net, .nv_proto_valid, .nv_proto, .nv_done);

   always #5 pclk = ~pclk;

   // stack answers init a cycle later unless held off; hang guard
   always @(posedge pclk) begin
      proto_init_done <= proto_init & auto_done;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         test_done();
      end
   end

   // ********************
   // tasks
   // ********************
   task automatic chk(input string what, input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask

   // one apb transfer, then an idle edge so back-to-back calls never clash
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // power cycle with new switch positions and store contents
   task automatic boot(input logic [11:0] sw, input logic sv, input int w);
      presetn  <= 1'b0;
      switches <= sw;
      @(posedge pclk);
      nv_u.saved_q = sv;
      repeat (9) @(posedge pclk);
      presetn <= 1'b1;
      repeat (w) @(posedge pclk);
   endtask

   task automatic test_done();
      if (failures == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ********************
   // sequence
   // ********************
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {cyclic_start, proto_init_done, switches} = '0;
      {failures, n_checks, cyc} = '0;
      supply_ok = 1'b1;
      auto_done = 1'b1;
      nv_u.net_q = {1'b0, 32'h0A000005, 32'hFFFF0000, 32'h0A000001};
      boot(12'h610, 1'b0, 30);
      chk("proto", 32'(proto_sel), 32'h6);
      chk("ip", net_cfg.ip, 32'hC0A8030A);
      chk("mask", net_cfg.mask, 32'hFFFFFF00);
      chk("gw", net_cfg.gw, 32'hC0A80364);
      apb(1'b0, rsps_pkg::REG_IP, 32'h0);
      chk("reg_ip", rd, 32'hC0A8030A);
      apb(1'b1, 8'h1C, 32'h1);
      chk("unmapped", 32'(err), 32'h1);
      switches <= 12'h925;
      repeat (4) @(posedge pclk);
      chk("ip_hold", net_cfg.ip, 32'hC0A8030A);
      chk("proto_hold", 32'(proto_sel), 32'h6);
      cyclic_start <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("stored", {27'h0, nv_u.pv_q, nv_u.proto_q}, 32'h16);
      chk("irq_masked", 32'(irq), 32'h0);
      apb(1'b1, rsps_pkg::REG_IRQ_MSK, 32'h8);
      chk("irq_on", 32'(irq), 32'h1);
      apb(1'b1, rsps_pkg::REG_IRQ_ST, 32'hF);
      chk("irq_clr", 32'(irq), 32'h0);
      switches <= 12'h642;
      apb(1'b1, rsps_pkg::REG_CTRL, 32'h1);
      repeat (30) @(posedge pclk);
      chk("restart", net_cfg.ip, 32'hC0A8032A);
      cyclic_start <= 1'b0;
      auto_done <= 1'b0;
      boot(12'h325, 1'b0, 10);
      chk("init_dark", {30'h0, net_en, run_indicator}, 32'h0);
      repeat (INIT_C) @(posedge pclk);
      chk("init_end", 32'(net_en), 32'h1);
      chk("proto_kept", 32'(proto_sel), 32'h6);
      auto_done <= 1'b1;
      boot(12'h600, 1'b1, 30);
      chk("sv_ip", net_cfg.ip, 32'h0A000005);
      chk("sv_mask", net_cfg.mask, 32'hFFFF0000);
      chk("sv_gw", net_cfg.gw, 32'h0A000001);
      nv_u.net_q.ip <= 32'h0A000107;
      repeat (2) @(posedge pclk);
      chk("sv_hold", net_cfg.ip, 32'h0A000005);
      boot(12'h699, 1'b1, 30);
      chk("sv_699", net_cfg.ip, 32'h0A000163);
      boot(12'h979, 1'b1, 3);
      hi = 0;
      repeat (12) @(posedge pclk) hi += red;
      chk("red_blink", 32'(hi > 0 && hi < 12), 32'h1);
      chk("fact_off", 32'(net_en), 32'h0);
      repeat (30) @(posedge pclk);
      chk("erased", {30'h0, nv_u.pv_q, nv_u.saved_q}, 32'h0);
      chk("green", {30'h0, red, green}, 32'h1);
      supply_ok <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("red", {30'h0, red, green}, 32'h2);
      supply_ok <= 1'b1;
      foreach (bad[i]) begin
         boot(bad[i], 1'b0, 30);
         hi = 0;
         repeat (8) @(posedge pclk) hi += run_indicator;
         chk("blink", 32'(hi > 0 && hi < 8), 32'h1);
         chk("net_off", 32'(net_en), 32'h0);
      end
      boot(12'h325, 1'b0, 30);
      chk("proto_3", 32'(proto_sel), 32'h3);
      boot(12'h650, 1'b0, 30);
      chk("ip_new", net_cfg.ip, 32'hC0A80332);
      chk("gw_new", net_cfg.gw, 32'hC0A80364);
      cyclic_start <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("restored", {27'h0, nv_u.pv_q, nv_u.proto_q}, 32'h16);
      test_done();
   end
endmodule

bind rsps_top rsps_top_sva #(
   .INIT_CYCLES(INIT_CYCLES), .BLINK_HALF(BLINK_HALF)) sva_u (
   .pclk, .presetn, .psel, .penable, .pready, .pslverr, .nv_saved,
   .nv_wr_proto, .nv_wr_proto_val, .nv_factory, .cyclic_start, .proto_init,
   .proto_sel, .net_cfg, .net_en, .supply_ok, .run_indicator,
   .system_supply_indicator_red, .system_supply_indicator_green);
